// [pkg/crba_pkg.sv]
// Constants and carrier types for the coefficient RAM block addressing logic
// Contract
// - Each channel RAM holds 40 words in five blocks of eight consecutive words.
// - A command carries only a 3-bit block address; low three bits are internal.
// - All eight words of a block are accessed in turn, counting 111 down to 000.
// - Block 100 reaches receive gain words 39-36 and receive response words 35-32 together.
// - Block 010 words 23-21: generator one amplitude, frequency, generator zero amplitude.
// - Word 20 is generator zero frequency; words 19-16 are the transmit-side gain set.
// - Block 000 impedance words 0-7, 001 echo 8-15, 011 transmit response 30-24, gain 31.
`default_nettype none
package crba_pkg;
  localparam int unsigned WORD_COUNT = 40;
  localparam int unsigned BLOCK_COUNT = 5;
  localparam int unsigned BLOCK_WORDS = 8;
  localparam int unsigned BLOCK_AW = 3;
  localparam int unsigned WORD_AW = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CHAN_W = 2;

  localparam logic [BLOCK_AW-1:0] BLK_IMPEDANCE = 3'h0;
  localparam logic [BLOCK_AW-1:0] BLK_ECHO = 3'h1;
  localparam logic [BLOCK_AW-1:0] BLK_TONE_TXSIDE = 3'h2;
  localparam logic [BLOCK_AW-1:0] BLK_TRANSMIT = 3'h3;
  localparam logic [BLOCK_AW-1:0] BLK_RECEIVE = 3'h4;
  localparam logic [BLOCK_AW-1:0] WORD_FIRST = 3'h7;
  localparam logic [BLOCK_AW-1:0] WORD_LAST = 3'h0;

  // Function of an addressed word
  typedef enum logic [3:0] {
    FN_IMPEDANCE_MATCH_FILTER_COEFFS,
    FN_ECHO_CANCEL_FILTER_COEFFS,
    FN_TRANSMIT_SIDE_GAIN_SET,
    FN_TONE0_FREQ,
    FN_TONE0_AMPL,
    FN_TONE1_FREQ,
    FN_TONE1_AMPL,
    FN_TRANSMIT_FREQ_RESPONSE_COEFFS,
    FN_TRANSMIT_GAIN_COEFFS,
    FN_RECEIVE_FREQ_RESPONSE_COEFFS,
    FN_RECEIVE_GAIN_COEFFS,
    FN_NONE
  } crba_func_type;

  // Command from the host control port decoder
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [BLOCK_AW-1:0] block;
    logic write;
  } crba_cmd_type;

  // One word step of a block access
  typedef struct packed {
    logic valid;
    logic write;
    logic [CHAN_W-1:0] channel;
    logic [WORD_AW-1:0] wordAddr;
    logic [DATA_W-1:0] data;
    logic lastWord;
  } crba_word_type;
endpackage
`default_nettype wire

// [rtl/crba_block_addressing.sv]
// Block addressing sequencer and per-channel coefficient store
`timescale 1ns/1ps
`default_nettype none
module crba_block_addressing (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire crba_pkg::crba_cmd_type cmd,
  input wire logic wrDataValid,
  input wire logic [crba_pkg::DATA_W-1:0] wrData,
  output logic cmdReady,
  output logic cmdError,
  output crba_pkg::crba_word_type wordOut,
  output crba_pkg::crba_func_type wordFunc
);
  localparam int unsigned NCH = 1 << crba_pkg::CHAN_W;
  localparam int unsigned MEM_AW = $clog2(NCH * crba_pkg::WORD_COUNT);

  typedef enum logic [1:0] {CRBA_IDLE, CRBA_STEP} crba_state_type;

  crba_state_type state_reg;
  logic [crba_pkg::BLOCK_AW-1:0] block_reg;
  logic [crba_pkg::BLOCK_AW-1:0] low_reg;
  logic [crba_pkg::CHAN_W-1:0] chan_reg;
  logic write_reg;
  logic [crba_pkg::DATA_W-1:0] mem [NCH * crba_pkg::WORD_COUNT];
  logic [crba_pkg::WORD_AW-1:0] curAddr;
  logic stepGo;

  // Word address is block bits above the internal low count
  function automatic logic [crba_pkg::WORD_AW-1:0] word_addr(
    input logic [crba_pkg::BLOCK_AW-1:0] blk, input logic [crba_pkg::BLOCK_AW-1:0] low);
    word_addr = {blk, low};
  endfunction

  function automatic crba_pkg::crba_func_type word_func(input logic [crba_pkg::WORD_AW-1:0] a);
    logic [crba_pkg::BLOCK_AW-1:0] blk;
    logic [crba_pkg::BLOCK_AW-1:0] low;
    blk = a[crba_pkg::WORD_AW-1:crba_pkg::BLOCK_AW];
    low = a[crba_pkg::BLOCK_AW-1:0];
    word_func = crba_pkg::FN_NONE;
    unique case (blk)
      crba_pkg::BLK_IMPEDANCE: word_func = crba_pkg::FN_IMPEDANCE_MATCH_FILTER_COEFFS;
      crba_pkg::BLK_ECHO: word_func = crba_pkg::FN_ECHO_CANCEL_FILTER_COEFFS;
      crba_pkg::BLK_TONE_TXSIDE: begin
        unique case (low)
          3'h7: word_func = crba_pkg::FN_TONE1_AMPL;
          3'h6: word_func = crba_pkg::FN_TONE1_FREQ;
          3'h5: word_func = crba_pkg::FN_TONE0_AMPL;
          3'h4: word_func = crba_pkg::FN_TONE0_FREQ;
          default: word_func = crba_pkg::FN_TRANSMIT_SIDE_GAIN_SET;
        endcase
      end
      crba_pkg::BLK_TRANSMIT: begin
        if (low == crba_pkg::WORD_FIRST) begin
          word_func = crba_pkg::FN_TRANSMIT_GAIN_COEFFS;
        end else begin
          word_func = crba_pkg::FN_TRANSMIT_FREQ_RESPONSE_COEFFS;
        end
      end
      crba_pkg::BLK_RECEIVE: begin
        // Both receive sets share one block, so one command loads both
        if (low[2]) begin
          word_func = crba_pkg::FN_RECEIVE_GAIN_COEFFS;
        end else begin
          word_func = crba_pkg::FN_RECEIVE_FREQ_RESPONSE_COEFFS;
        end
      end
      default: word_func = crba_pkg::FN_NONE;
    endcase
  endfunction

  // Flat store index: one run of forty words per channel, sized to the store
  function automatic logic [MEM_AW-1:0] mem_index(
    input logic [crba_pkg::CHAN_W-1:0] ch, input logic [crba_pkg::WORD_AW-1:0] a);
    mem_index = MEM_AW'(ch) * MEM_AW'(crba_pkg::WORD_COUNT) + MEM_AW'(a);
  endfunction

  function automatic logic block_ok(input logic [crba_pkg::BLOCK_AW-1:0] blk);
    block_ok = blk < crba_pkg::BLOCK_AW'(crba_pkg::BLOCK_COUNT);
  endfunction

  assign curAddr = word_addr(block_reg, low_reg);
  // A write step waits for its data word; reads advance every enabled cycle
  assign stepGo = (state_reg == CRBA_STEP) && (!write_reg || wrDataValid);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CRBA_IDLE;
      block_reg <= crba_pkg::WORD_LAST;
      low_reg <= crba_pkg::WORD_FIRST;
      chan_reg <= '0;
      write_reg <= 1'b0;
    end else if (clkEn) begin
      unique case (state_reg)
        CRBA_IDLE: begin
          if (cmdValid && block_ok(cmd.block)) begin
            state_reg <= CRBA_STEP;
            block_reg <= cmd.block;
            low_reg <= crba_pkg::WORD_FIRST;
            chan_reg <= cmd.channel;
            write_reg <= cmd.write;
          end
        end
        CRBA_STEP: begin
          if (stepGo) begin
            if (low_reg == crba_pkg::WORD_LAST) begin
              state_reg <= CRBA_IDLE;
            end else begin
              low_reg <= low_reg - 3'h1;
            end
          end
        end
      endcase
    end
  end

  // Advisory only: a command raised while busy is dropped, not queued
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdReady <= 1'b0;
      cmdError <= 1'b0;
    end else if (clkEn) begin
      cmdReady <= (state_reg == CRBA_IDLE) && !cmdValid;
      cmdError <= (state_reg == CRBA_IDLE) && cmdValid && !block_ok(cmd.block);
    end
  end

  // Storage has no reset; contents are undefined until software loads them
  always_ff @(posedge clk) begin
    if (clkEn && stepGo && write_reg) begin
      mem[mem_index(chan_reg, curAddr)] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wordOut <= '0;
      wordFunc <= crba_pkg::FN_NONE;
    end else if (clkEn) begin
      wordOut.valid <= stepGo;
      wordOut.write <= write_reg;
      wordOut.channel <= chan_reg;
      wordOut.wordAddr <= curAddr;
      wordOut.data <= write_reg ? wrData : mem[mem_index(chan_reg, curAddr)];
      wordOut.lastWord <= stepGo && (low_reg == crba_pkg::WORD_LAST);
      wordFunc <= stepGo ? word_func(curAddr) : crba_pkg::FN_NONE;
    end
  end

  // Helper for a_eight_words: words issued so far in the running access
  logic [crba_pkg::BLOCK_AW:0] wordsSeen_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wordsSeen_reg <= '0;
    end else if (clkEn && stepGo) begin
      wordsSeen_reg <= (low_reg == crba_pkg::WORD_LAST) ? '0 : wordsSeen_reg + 1'b1;
    end
  end

  sequence s_step;
    clkEn && stepGo;
  endsequence

  sequence s_start;
    cmdValid && state_reg == CRBA_IDLE && block_ok(cmd.block);
  endsequence

  sequence s_first_word;
    wordOut.valid && wordOut.wordAddr[2:0] == 3'h7;
  endsequence

  a_block_starts_high: assert property (@(posedge clk) disable iff (!reset_n)
    (s_start ##0 (clkEn && !cmd.write)) ##1 clkEn[*2] |-> s_first_word)
    else $error("Block access did not start at the highest word");
  a_count_down: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && stepGo && low_reg != 3'h0 |=> low_reg == $past(low_reg) - 3'h1)
    else $error("Low word address did not count down by one");
  a_last_word_zero: assert property (@(posedge clk) disable iff (!reset_n)
    wordOut.lastWord |-> wordOut.valid && wordOut.wordAddr[2:0] == 3'h0)
    else $error("Last word flag not on word zero");
  a_block_fixed: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == CRBA_STEP && $past(state_reg) == CRBA_STEP |-> $stable(block_reg))
    else $error("Block address changed during an access");
  a_range_ok: assert property (@(posedge clk) disable iff (!reset_n)
    wordOut.valid |-> wordOut.wordAddr < 6'h28)
    else $error("Word address beyond the forty word store");
  a_bad_block: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_reg == CRBA_IDLE && cmdValid && cmd.block > 3'h4 |=>
      cmdError && state_reg == CRBA_IDLE)
    else $error("Out of range block not refused");
  a_receive_pair: assert property (@(posedge clk) disable iff (!reset_n)
    wordOut.valid && wordOut.wordAddr[5:3] == 3'h4 |->
      wordFunc == (wordOut.wordAddr[2] ? crba_pkg::FN_RECEIVE_GAIN_COEFFS
                                       : crba_pkg::FN_RECEIVE_FREQ_RESPONSE_COEFFS))
    else $error("Receive block word function wrong");
  a_tone_map: assert property (@(posedge clk) disable iff (!reset_n)
    wordOut.valid && wordOut.wordAddr == 6'h17 |-> wordFunc == crba_pkg::FN_TONE1_AMPL)
    else $error("Word 23 is not tone one amplitude");
  a_tone0_freq: assert property (@(posedge clk) disable iff (!reset_n)
    wordOut.valid && wordOut.wordAddr == 6'h14 |-> wordFunc == crba_pkg::FN_TONE0_FREQ)
    else $error("Word 20 is not tone zero frequency");
  a_tx_gain: assert property (@(posedge clk) disable iff (!reset_n)
    wordOut.valid && wordOut.wordAddr == 6'h1f |-> wordFunc == crba_pkg::FN_TRANSMIT_GAIN_COEFFS)
    else $error("Word 31 is not transmit gain");

  // Pacing and length of an access
  a_ready_idle: assert property (@(posedge clk) disable iff (!reset_n)
    cmdReady |-> state_reg == CRBA_IDLE)
    else $error("Ready shown during a block access");
  a_read_no_stall: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_reg == CRBA_STEP && !write_reg |=> wordOut.valid)
    else $error("Read step did not issue a word");
  a_write_holds: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_reg == CRBA_STEP && write_reg && !wrDataValid |=>
      !wordOut.valid && $stable(low_reg))
    else $error("Write step advanced without a data word");
  a_write_data: assert property (@(posedge clk) disable iff (!reset_n)
    s_step ##0 write_reg |=> wordOut.valid && wordOut.data == $past(wrData))
    else $error("Written word not passed through");
  a_eight_words: assert property (@(posedge clk) disable iff (!reset_n)
    s_step ##0 low_reg == crba_pkg::WORD_LAST |-> wordsSeen_reg == 4'h7)
    else $error("Block access did not hold eight words");
endmodule // crba_block_addressing
`default_nettype wire

// [test/crba_host_model.sv]
// Host side of the command port: issues block commands and feeds write words
`timescale 1ns/1ps
`default_nettype none
module crba_host_model (
  input wire logic clk,
  input wire logic clkEn,
  input wire crba_pkg::crba_word_type wordOut,
  output logic cmdValid,
  output crba_pkg::crba_cmd_type cmd,
  output logic wrDataValid,
  output logic [crba_pkg::DATA_W-1:0] wrData
);
  int timeouts = 0;

  initial begin
    cmdValid = 1'b0;
    cmd = '0;
    wrDataValid = 1'b0;
    wrData = '0;
  end

  // Words of d go out highest address first; stall sets how often a step is held off
  task automatic send(input logic [1:0] ch, input logic [2:0] blk, input logic wr,
                      input logic [127:0] d, input int stall);
    int i;
    int t;
    i = 0;
    t = 0;
    cmdValid <= 1'b1;
    cmd <= '{channel: ch, block: blk, write: wr};
    do @(posedge clk); while (!clkEn);
    cmdValid <= 1'b0;
    cmd <= ~{ch, blk, wr};
    while (wr && blk < 3'h5 && i < 8) begin
      wrDataValid <= ($urandom_range(stall, 0) == 0);
      wrData <= d[16*i +: 16];
      do @(posedge clk); while (!clkEn);
      if (wrDataValid) i++;
    end
    wrDataValid <= 1'b0;
    wrData <= ~wrData;
    // Next command only once the last word of a valid block has been seen, or after 200 cycles; a refused block waits three cycles
    while (blk < 3'h5 && !(clkEn && wordOut.valid && wordOut.lastWord) && t < 200) begin
      @(posedge clk);
      t++;
    end
    if (t >= 200) timeouts++;
    if (blk > 3'h4) repeat (3) @(posedge clk);
  endtask
endmodule // crba_host_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the block addressing sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset_n;
  logic clkEn = 1'b1;
  logic cmdValid;
  crba_pkg::crba_cmd_type cmd;
  logic wrDataValid;
  logic [15:0] wrData;
  logic cmdReady;
  logic cmdError;
  crba_pkg::crba_word_type wordOut;
  crba_pkg::crba_func_type wordFunc;
  int miscompares = 0;
  int nChecks = 0;
  int expErr = 0;
  int nErr = 0;
  logic [15:0] mem [160];
  crba_pkg::crba_word_type qE[$];
  crba_pkg::crba_word_type e;

  crba_block_addressing u_crba_block_addressing (.clk(clk), .reset_n(reset_n),
    .clkEn(clkEn), .cmdValid(cmdValid), .cmd(cmd), .wrDataValid(wrDataValid),
    .wrData(wrData), .cmdReady(cmdReady), .cmdError(cmdError), .wordOut(wordOut),
    .wordFunc(wordFunc));
  crba_host_model u_crba_host_model (.clk(clk), .clkEn(clkEn), .wordOut(wordOut),
    .cmdValid(cmdValid), .cmd(cmd), .wrDataValid(wrDataValid), .wrData(wrData));

  always #4 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic crba_pkg::crba_func_type fnOf(input int a);
    if (a < 8) return crba_pkg::FN_IMPEDANCE_MATCH_FILTER_COEFFS;
    if (a < 16) return crba_pkg::FN_ECHO_CANCEL_FILTER_COEFFS;
    if (a < 20) return crba_pkg::FN_TRANSMIT_SIDE_GAIN_SET;
    if (a == 20) return crba_pkg::FN_TONE0_FREQ;
    if (a == 21) return crba_pkg::FN_TONE0_AMPL;
    if (a == 22) return crba_pkg::FN_TONE1_FREQ;
    if (a == 23) return crba_pkg::FN_TONE1_AMPL;
    if (a < 31) return crba_pkg::FN_TRANSMIT_FREQ_RESPONSE_COEFFS;
    if (a == 31) return crba_pkg::FN_TRANSMIT_GAIN_COEFFS;
    if (a < 36) return crba_pkg::FN_RECEIVE_FREQ_RESPONSE_COEFFS;
    return crba_pkg::FN_RECEIVE_GAIN_COEFFS;
  endfunction

  always @(posedge clk) begin
    clkEn <= ($urandom_range(7, 0) != 0);
    if (reset_n && clkEn && cmdError) nErr++;
    if (reset_n && clkEn && wordOut.valid) begin
      e = (qE.size() > 0) ? qE.pop_front() : '0;
      chk("word", 32'(e), 32'(wordOut));
      chk("ready", 32'h0, 32'(cmdReady));
      chk("function", 32'(fnOf(int'(e.wordAddr))), 32'(wordFunc));
    end
  end

  task automatic run(input logic [1:0] ch, input logic [2:0] b, input logic wr);
    logic [127:0] d;
    int a;
    d = {$urandom, $urandom, $urandom, $urandom};
    if (b > 3'h4) expErr++;
    else for (int k = 0; k < 8; k++) begin
      a = int'(b) * 8 + 7 - k;
      if (wr) mem[int'(ch) * 40 + a] = d[16*k +: 16];
      qE.push_back('{valid: 1'b1, write: wr, channel: ch, wordAddr: 6'(a),
                     data: mem[int'(ch) * 40 + a], lastWord: (k == 7)});
    end
    u_crba_host_model.send(ch, b, wr, d, int'(b));
  endtask

  task automatic complete_run();
    if (miscompares == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    void'($urandom(32'h303cbbbe));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // Writes on every channel first so that no read meets an unwritten word
    for (int w = 1; w >= 0; w--)
      for (int c = 0; c < 4; c++)
        for (int b = 0; b < 5; b++) run(2'(c), 3'(b), w[0]);
    for (int b = 5; b < 8; b++) run(2'(b), 3'(b), b[0]);
    repeat (10) @(posedge clk);
    chk("refusals", 32'(expErr), 32'(nErr));
    chk("pending words", 32'h0, 32'(qE.size()));
    chk("host waits", 32'h0, 32'(u_crba_host_model.timeouts));
    chk("ready", 32'h1, 32'(cmdReady));
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
